//--- src/eepw_pkg.sv
// shared constants and types for the serial eeprom write path
package eepw_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS         = 100;
  localparam int PROGRAM_CYCLE_TIME_NS = 5000000;
  localparam int PROGRAM_CYCLE_CLKS    = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_CNT_W            = 16;
  localparam int SCL_PERIOD_NS         = 10000;
  localparam int SCL_QUARTER_CLKS      = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam int QTR_CNT_W             = 8;
  // ****************************************
  // memory layout
  // ****************************************
  localparam int ADDR_W     = 12;
  localparam int OFS_W      = 5;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_COUNT = 128;
  localparam int MEM_BYTES  = PAGE_BYTES * PAGE_COUNT;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  // device type codes, values are arbitrary
  localparam logic [3:0] TYPE_MAIN   = 4'h5;
  localparam logic [3:0] TYPE_SERIAL = 4'h6;
  // ****************************************
  // host registers on apb
  // ****************************************
  localparam logic [7:0] CMD_OFS       = 8'h00;
  localparam logic [7:0] STAT_OFS      = 8'h04;
  localparam int         CMD_DATA_LSB  = 0;
  localparam int         CMD_OP_LSB    = 8;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_NACK_BIT = 1;
  typedef enum logic [1:0] {
    OP_NONE  = 2'h0,
    OP_START = 2'h1,
    OP_WRITE = 2'h2,
    OP_STOP  = 2'h3
  } eepw_op_t;
  // ****************************************
  // state machines
  // ****************************************
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_DEV  = 3'h1,
    D_AHI  = 3'h3,
    D_ALO  = 3'h2,
    D_DATA = 3'h6,
    D_PROG = 3'h7,
    D_SKIP = 3'h4
  } eepw_dst_t;
  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_WRITE = 2'h3,
    H_STOP  = 2'h2
  } eepw_hst_t;
endpackage

//--- src/eepw_if.sv
// two-wire bus between the host end and the device end
interface eepw_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;
  // open-drain wired and, released line reads high
  assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe_n);
  modport host (output scl, output m_sda_o, output m_sda_oe_n, input sda);
endinterface

//--- src/eepw_cond.sv
// edge and start/stop detector for the two-wire bus
module eepw_cond (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  typedef struct packed {
    logic scl_reg;
    logic sda_reg;
  } eepw_cond_st_t;

  eepw_cond_st_t r_reg;
  eepw_cond_st_t r_next;

  always_comb begin
    r_next.scl_reg = scl;
    r_next.sda_reg = sda;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg <= '{scl_reg: 1'b1, sda_reg: 1'b1};
    end else begin
      r_reg <= r_next;
    end
  end

  assign scl_rise  = scl & ~r_reg.scl_reg;
  assign scl_fall  = ~scl & r_reg.scl_reg;
  assign start_det = scl & r_reg.scl_reg & r_reg.sda_reg & ~sda;
  assign stop_det  = scl & r_reg.scl_reg & ~r_reg.sda_reg & sda;
endmodule

//--- src/eepw_dev.sv
// device end: address decode, page load and self-timed programming
// Function
// - array is 128 pages of 32 bytes
// - upper nibble type code picks array or serial
// - bits 3..1 must match address select pins
// - open address select pins count as zero
// - bit 0 one reads, zero writes
// - ack device byte on match, else release
// - master sends two word address bytes
// - first byte low nibble gives bits 11..8
// - second byte gives bits 7..0, acked
// - serial region needs bits 11..10 one-zero; here serial writes are acked but never programmed
// - write: start, device, addresses, data bytes
// - stop after data starts timed programming
// - bus ignored while programming runs
// - one cycle commits up to one page
// - ack every data byte, program at stop
// - only low five bits increment, page wraps
// - master avoids sending past page end
// - no ack to polling until programming ends
// - cycle time runs stop to acked start
// - protect pin high blocks all writes
// - protect pin sampled at stop only
// - protected write acked, no cycle, ready
// - sample on scl rise, drive on fall, msb first
module eepw_dev #(
  parameter int PROG_CYCLES = eepw_pkg::PROGRAM_CYCLE_CLKS
) (
  input  wire logic                        REF_CLK,
  input  wire logic                        RST_B,
  input  wire logic                        HW_ADDR_SEL_BIT0,
  input  wire logic                        HW_ADDR_SEL_BIT1,
  input  wire logic                        HW_ADDR_SEL_BIT2,
  input  wire logic                        WRITE_PROTECT,
  input  wire logic [eepw_pkg::ADDR_W-1:0] PEEK_ADDR,
  output logic      [7:0]                  PEEK_DATA,
  output logic                             PROGRAMMING,
  eepw_if.dev                              BUS
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    eepw_pkg::eepw_dst_t                   state;
    logic [3:0]                            bit_cnt;
    logic                                  in_ack;
    logic                                  ack_drive;
    logic [7:0]                            shift;
    logic                                  serial_sel;
    logic [eepw_pkg::ADDR_W-1:0]           addr;
    logic                                  got_data;
    logic [eepw_pkg::PAGE_BYTES-1:0]       mask;
    logic [eepw_pkg::PAGE_BYTES-1:0][7:0]  page_buf;
    logic [eepw_pkg::PROG_CNT_W-1:0]       prog_cnt;
    logic [7:0]                            peek;
  } eepw_dev_st_t;

  localparam logic [eepw_pkg::PROG_CNT_W-1:0] PROG_LAST =
    eepw_pkg::PROG_CNT_W'(PROG_CYCLES - 1);

  eepw_dev_st_t r_reg;
  eepw_dev_st_t r_next;
  logic [7:0]   mem [0:eepw_pkg::MEM_BYTES-1];
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic         commit;
  logic         active;
  logic [2:0]   pins;

  // ****************************************
  // address byte decode
  // ****************************************
  function automatic logic dev_match(input logic [7:0] b,
                                     input logic [2:0] p);
    logic type_ok;
    type_ok = (b[7:4] == eepw_pkg::TYPE_MAIN) |
              (b[7:4] == eepw_pkg::TYPE_SERIAL);
    return type_ok & (b[3:1] == p);
  endfunction

  eepw_cond u_cond (
    .clk       (REF_CLK),
    .rst_b     (RST_B),
    .scl       (BUS.scl),
    .sda       (BUS.sda),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // unconnected pins are tied low at the top level
  assign pins = {HW_ADDR_SEL_BIT2, HW_ADDR_SEL_BIT1, HW_ADDR_SEL_BIT0};
  assign commit = (r_reg.state == eepw_pkg::D_PROG) &&
                  (r_reg.prog_cnt == PROG_LAST);
  assign active = (r_reg.state == eepw_pkg::D_DEV) ||
                  (r_reg.state == eepw_pkg::D_AHI) ||
                  (r_reg.state == eepw_pkg::D_ALO) ||
                  (r_reg.state == eepw_pkg::D_DATA);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_next = r_reg;
    r_next.peek = mem[PEEK_ADDR];
    if (r_reg.state == eepw_pkg::D_PROG) begin
      // polling gets no ack until done
      if (commit) begin
        r_next.state = eepw_pkg::D_IDLE;
        r_next.mask  = '0;
      end else begin
        r_next.prog_cnt = r_reg.prog_cnt + 1'b1;
      end
    end else if (start_det) begin
      r_next.state     = eepw_pkg::D_DEV;
      r_next.bit_cnt   = 4'h0;
      r_next.in_ack    = 1'b0;
      r_next.ack_drive = 1'b0;
      r_next.got_data  = 1'b0;
      r_next.mask      = '0;
    end else if (stop_det) begin
      r_next.in_ack    = 1'b0;
      r_next.ack_drive = 1'b0;
      if (r_reg.state == eepw_pkg::D_DATA && r_reg.got_data &&
          !WRITE_PROTECT && !r_reg.serial_sel) begin
        r_next.state    = eepw_pkg::D_PROG;
        r_next.prog_cnt = '0;
      end else begin
        r_next.state = eepw_pkg::D_IDLE;
        r_next.mask  = '0;
      end
    end else if (active || r_reg.in_ack) begin
      if (scl_rise && !r_reg.in_ack &&
          r_reg.bit_cnt != eepw_pkg::BYTE_BITS) begin
        r_next.shift   = {r_reg.shift[6:0], BUS.sda};
        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
      end
      if (scl_fall && r_reg.in_ack) begin
        r_next.in_ack    = 1'b0;
        r_next.ack_drive = 1'b0;
        r_next.bit_cnt   = 4'h0;
      end else if (scl_fall &&
                   r_reg.bit_cnt == eepw_pkg::BYTE_BITS) begin
        r_next.in_ack = 1'b1;
        case (r_reg.state)
          eepw_pkg::D_DEV: begin
            if (dev_match(r_reg.shift, pins)) begin
              r_next.ack_drive  = 1'b1;
              r_next.serial_sel =
                (r_reg.shift[7:4] == eepw_pkg::TYPE_SERIAL);
              if (!r_reg.shift[0]) begin
                r_next.state = eepw_pkg::D_AHI;
              end else begin
                r_next.state = eepw_pkg::D_SKIP;
              end
            end else begin
              r_next.ack_drive = 1'b0;
              r_next.state     = eepw_pkg::D_SKIP;
            end
          end
          eepw_pkg::D_AHI: begin
            r_next.addr[11:8] = r_reg.shift[3:0];
            r_next.ack_drive  = 1'b1;
            r_next.state      = eepw_pkg::D_ALO;
          end
          eepw_pkg::D_ALO: begin
            r_next.addr[7:0] = r_reg.shift;
            r_next.ack_drive = 1'b1;
            r_next.state     = eepw_pkg::D_DATA;
          end
          eepw_pkg::D_DATA: begin
            r_next.page_buf[r_reg.addr[4:0]] = r_reg.shift;
            r_next.mask[r_reg.addr[4:0]]     = 1'b1;
            r_next.addr[4:0] = r_reg.addr[4:0] + 5'h01;
            r_next.got_data  = 1'b1;
            r_next.ack_drive = 1'b1;
          end
          default: begin
            r_next.ack_drive = 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      r_reg.state      <= eepw_pkg::D_IDLE;
      r_reg.bit_cnt    <= 4'h0;
      r_reg.in_ack     <= 1'b0;
      r_reg.ack_drive  <= 1'b0;
      r_reg.shift      <= 8'h00;
      r_reg.serial_sel <= 1'b0;
      r_reg.addr       <= eepw_pkg::ADDR_RST;
      r_reg.got_data   <= 1'b0;
      r_reg.mask       <= '0;
      r_reg.page_buf   <= '0;
      r_reg.prog_cnt   <= '0;
      r_reg.peek       <= 8'h00;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // array commit
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < eepw_pkg::PAGE_BYTES; i++) begin
      if (commit && r_reg.mask[i]) begin
        mem[{r_reg.addr[11:5], 5'(i)}] <= r_reg.page_buf[i];
      end
    end
  end

  assign BUS.d_sda_o    = 1'b0;
  assign BUS.d_sda_oe_n = ~r_reg.ack_drive;
  assign PEEK_DATA      = r_reg.peek;
  assign PROGRAMMING    = (r_reg.state == eepw_pkg::D_PROG);
endmodule

//--- src/eepw_host.sv
// host end: apb-driven two-wire master for writes and polling
module eepw_host (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  eepw_if.host             BUS
);
  typedef struct packed {
    eepw_pkg::eepw_hst_t              state;
    logic [1:0]                       step;
    logic [3:0]                       bit_idx;
    logic [eepw_pkg::QTR_CNT_W-1:0]   qcnt;
    logic [7:0]                       shift;
    logic                             scl;
    logic                             sda_low;
    logic                             nack;
    logic [31:0]                      rdata;
  } eepw_host_st_t;

  localparam logic [eepw_pkg::QTR_CNT_W-1:0] QTR_LAST =
    eepw_pkg::QTR_CNT_W'(eepw_pkg::SCL_QUARTER_CLKS - 1);

  eepw_host_st_t       r_reg;
  eepw_host_st_t       r_next;
  eepw_pkg::eepw_op_t  op;
  logic                tick;
  logic                mapped;
  logic                wr_cmd;

  assign op     = eepw_pkg::eepw_op_t'(PWDATA[eepw_pkg::CMD_OP_LSB +: 2]);
  assign mapped = (PADDR == eepw_pkg::CMD_OFS) ||
                  (PADDR == eepw_pkg::STAT_OFS);
  assign wr_cmd = PSEL && PENABLE && PWRITE &&
                  (PADDR == eepw_pkg::CMD_OFS);
  assign tick   = (r_reg.qcnt == QTR_LAST);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    r_next = r_reg;
    if (PSEL && !PENABLE) begin
      r_next.rdata = 32'h0000_0000;
      if (PADDR == eepw_pkg::STAT_OFS) begin
        r_next.rdata[eepw_pkg::STAT_BUSY_BIT] =
          (r_reg.state != eepw_pkg::H_IDLE);
        r_next.rdata[eepw_pkg::STAT_NACK_BIT] = r_reg.nack;
      end
    end
    if (r_reg.state == eepw_pkg::H_IDLE) begin
      r_next.qcnt = '0;
      if (wr_cmd && op != eepw_pkg::OP_NONE) begin
        r_next.step    = 2'h0;
        r_next.bit_idx = 4'h0;
        r_next.shift   = PWDATA[eepw_pkg::CMD_DATA_LSB +: 8];
        case (op)
          eepw_pkg::OP_START: r_next.state = eepw_pkg::H_START;
          eepw_pkg::OP_WRITE: r_next.state = eepw_pkg::H_WRITE;
          default:            r_next.state = eepw_pkg::H_STOP;
        endcase
      end
    end else if (!tick) begin
      r_next.qcnt = r_reg.qcnt + 1'b1;
    end else begin
      r_next.qcnt = '0;
      r_next.step = r_reg.step + 2'h1;
      case (r_reg.state)
        eepw_pkg::H_START: begin
          case (r_reg.step)
            2'h0:    r_next.sda_low = 1'b0;
            2'h1:    r_next.scl = 1'b1;
            2'h2:    r_next.sda_low = 1'b1;
            default: begin
              r_next.scl   = 1'b0;
              r_next.state = eepw_pkg::H_IDLE;
            end
          endcase
        end
        eepw_pkg::H_WRITE: begin
          case (r_reg.step)
            2'h0: begin
              r_next.sda_low = (r_reg.bit_idx != eepw_pkg::BYTE_BITS) &
                               ~r_reg.shift[7];
            end
            2'h1: r_next.scl = 1'b1;
            2'h2: begin
              if (r_reg.bit_idx == eepw_pkg::BYTE_BITS) begin
                r_next.nack = BUS.sda;
              end
            end
            default: begin
              r_next.scl   = 1'b0;
              r_next.shift = {r_reg.shift[6:0], 1'b0};
              if (r_reg.bit_idx == eepw_pkg::BYTE_BITS) begin
                r_next.state = eepw_pkg::H_IDLE;
              end else begin
                r_next.bit_idx = r_reg.bit_idx + 4'h1;
              end
            end
          endcase
        end
        default: begin
          case (r_reg.step)
            2'h0:    r_next.sda_low = 1'b1;
            2'h1:    r_next.scl = 1'b1;
            default: begin
              r_next.sda_low = 1'b0;
              r_next.state   = eepw_pkg::H_IDLE;
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      r_reg.state   <= eepw_pkg::H_IDLE;
      r_reg.step    <= 2'h0;
      r_reg.bit_idx <= 4'h0;
      r_reg.qcnt    <= '0;
      r_reg.shift   <= 8'h00;
      r_reg.scl     <= 1'b1;
      r_reg.sda_low <= 1'b0;
      r_reg.nack    <= 1'b0;
      r_reg.rdata   <= 32'h0000_0000;
    end else begin
      r_reg <= r_next;
    end
  end

  assign PRDATA         = r_reg.rdata;
  assign PREADY         = 1'b1;
  assign PSLVERR        = PSEL & PENABLE & ~mapped;
  assign BUS.scl        = r_reg.scl;
  assign BUS.m_sda_o    = 1'b0;
  assign BUS.m_sda_oe_n = ~r_reg.sda_low;
endmodule

//--- test/eepw_asserts.sv
// concurrent checks on the two-wire link between the ends
module eepw_asserts #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic scl,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic sda,
  input wire logic PROGRAMMING
);
  // ****************************************
  // helpers
  // ****************************************
  int   cnt_reg;
  int   age_reg;
  logic scl_reg;
  logic sda_reg;
  logic stop;
  assign stop = scl && scl_reg && sda && !sda_reg;
  always_ff @(posedge REF_CLK) begin
    scl_reg <= scl;
    sda_reg <= sda;
    cnt_reg <= (!RST_B || !PROGRAMMING) ? 0 : cnt_reg + 1;
    age_reg <= !RST_B ? 100 : stop ? 0 : (age_reg < 100 ? age_reg + 1 : 100);
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  property p_od_low; !d_sda_oe_n |-> !d_sda_o; endproperty
  a_od_low: assert property (p_od_low)
    else $error("device drives sda high");
  property p_busy_quiet; PROGRAMMING |-> d_sda_oe_n; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("device acks while programming");
  property p_prog_len; $fell(PROGRAMMING) |-> cnt_reg == PROG_CYCLES;
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("programming cycle length wrong");
  property p_prog_max; cnt_reg <= PROG_CYCLES; endproperty
  a_prog_max: assert property (p_prog_max)
    else $error("programming cycle too long");
  property p_prog_stop; $rose(PROGRAMMING) |-> age_reg <= 4; endproperty
  a_prog_stop: assert property (p_prog_stop)
    else $error("programming began without stop");
  property p_ack_scl_low; $changed(d_sda_oe_n) |-> !scl; endproperty
  a_ack_scl_low: assert property (p_ack_scl_low)
    else $error("device sda changed while scl high");
  property p_ack_hold; $fell(d_sda_oe_n) |-> !d_sda_oe_n [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack released too soon");
  property p_ack_fall;
    $fell(d_sda_oe_n) |-> !scl && ($past(scl, 2) || $past(scl, 3)
      || $past(scl, 4));
  endproperty
  a_ack_fall: assert property (p_ack_fall)
    else $error("ack not launched after scl fall");
endmodule

//--- test/tb.sv
// self-checking bench joining host end and device end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 200;
  localparam logic [3:0] TM = eepw_pkg::TYPE_MAIN;
  localparam logic [3:0] TS = eepw_pkg::TYPE_SERIAL;
  localparam logic [7:0] DV = {TM, 4'h0};
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        prog;
  logic        wp = 1'b0;
  logic [2:0]  sel = 3'h5;
  logic [11:0] peek = 12'h000;
  logic [7:0]  pdat;
  logic [31:0] rd;
  logic        er;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [8:0]  rows [7] = '{{TM, 3'h5, 2'h0}, {TM, 3'h5, 2'h2},
    {TS, 3'h5, 2'h0}, {TM, 3'h4, 2'h1}, {TM, 3'h1, 2'h1},
    {TM, 3'h7, 2'h1}, {4'h7, 3'h5, 2'h1}};
  eepw_if bus ();
  eepw_host i_eepw_host (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUS(bus.host));
  eepw_dev #(.PROG_CYCLES(PC)) i_eepw_dev (.REF_CLK(clk), .RST_B(rst_b),
    .HW_ADDR_SEL_BIT0(sel[0]), .HW_ADDR_SEL_BIT1(sel[1]),
    .HW_ADDR_SEL_BIT2(sel[2]), .WRITE_PROTECT(wp), .PEEK_ADDR(peek),
    .PEEK_DATA(pdat), .PROGRAMMING(prog), .BUS(bus.dev));
  eepw_asserts #(.PROG_CYCLES(PC)) i_eepw_asserts (.REF_CLK(clk),
    .RST_B(rst_b), .scl(bus.scl), .d_sda_o(bus.d_sda_o),
    .d_sda_oe_n(bus.d_sda_oe_n), .sda(bus.sda), .PROGRAMMING(prog));
  // ****************************************
  // clock, timeout, tasks
  // ****************************************
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      $display("unexpected cycles exp under %0d got %0d", 60000, cyc);
      tally_and_finish();
    end
  end
  task automatic chk_bit(string nm, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic cmd(eepw_pkg::eepw_op_t o, logic [7:0] b, output logic nk);
    logic [31:0] r;
    logic        e;
    apb(1'b1, eepw_pkg::CMD_OFS, {22'h0, o, b}, r, e);
    do apb(1'b0, eepw_pkg::STAT_OFS, 32'h0, r, e);
    while (r[eepw_pkg::STAT_BUSY_BIT] !== 1'b0);
    nk = r[eepw_pkg::STAT_NACK_BIT];
  endtask
  task automatic op(eepw_pkg::eepw_op_t o);
    logic nk;
    cmd(o, 8'h00, nk);
  endtask
  task automatic wr(logic [7:0] b, logic e);
    logic nk;
    cmd(eepw_pkg::OP_WRITE, b, nk);
    chk_bit("nack", e, nk);
  endtask
  task automatic frame(logic [11:0] a, logic [7:0] d [$]);
    op(eepw_pkg::OP_START);
    wr(DV, 1'b0);
    wr({4'hE, a[11:8]}, 1'b0);
    wr(a[7:0], 1'b0);
    foreach (d[i]) wr(d[i], 1'b0);
    op(eepw_pkg::OP_STOP);
  endtask
  task automatic settle();
    for (int k = 0; k < 1000 && prog !== 1'b0; k++) @(posedge clk);
  endtask
  task automatic pk(logic [11:0] a, logic [7:0] e);
    @(posedge clk);
    peek <= a;
    repeat (3) @(posedge clk);
    chk_word("peek", {24'h0, e}, {24'h0, pdat});
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_bit("pready", 1'b1, pready);
    chk_word("prdata", 32'h0, prdata);
    chk_bit("prog", 1'b0, prog);
    chk_bit("scl", 1'b1, bus.scl);
    chk_bit("sda", 1'b1, bus.sda);
    $display("reset done");
    foreach (rows[i]) begin
      op(eepw_pkg::OP_START);
      wr(rows[i][8:1], rows[i][0]);
      op(eepw_pkg::OP_STOP);
      chk_bit("prog", 1'b0, prog);
    end
    $display("address table done");
    sel <= 3'h0;
    frame(12'h345, '{8'hC3});
    chk_bit("prog", 1'b1, prog);
    op(eepw_pkg::OP_START);
    wr(DV, 1'b1);
    op(eepw_pkg::OP_STOP);
    settle();
    op(eepw_pkg::OP_START);
    wr(DV, 1'b0);
    op(eepw_pkg::OP_STOP);
    chk_bit("prog", 1'b0, prog);
    pk(12'h345, 8'hC3);
    $display("byte write done");
    frame(12'h345, '{8'h5A});
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_bit("prog", 1'b0, prog);
    chk_bit("scl", 1'b1, bus.scl);
    chk_bit("sda", 1'b1, bus.sda);
    pk(12'h345, 8'hC3);
    $display("mid reset done");
    frame(12'h21E, '{8'hD0, 8'hD1, 8'hD2, 8'hD3});
    wp <= 1'b1;
    settle();
    for (int i = 0; i < 4; i++)
      pk({7'h10, 5'(5'h1E + i)}, 8'hD0 + 8'(i));
    $display("page write done");
    frame(12'h345, '{8'h3C});
    chk_bit("prog", 1'b0, prog);
    op(eepw_pkg::OP_START);
    wr(DV, 1'b0);
    op(eepw_pkg::OP_STOP);
    pk(12'h345, 8'hC3);
    wp <= 1'b0;
    $display("protected write done");
    op(eepw_pkg::OP_START);
    wr({TS, 4'h0}, 1'b0);
    wr(8'h08, 1'b0);
    wr(8'h00, 1'b0);
    wr(8'hA5, 1'b0);
    op(eepw_pkg::OP_STOP);
    chk_bit("prog", 1'b0, prog);
    $display("serial write done");
    apb(1'b0, 8'h08, 32'h0, rd, er);
    chk_bit("pslverr", 1'b1, er);
    chk_word("prdata", 32'h0, rd);
    $display("unmapped access done");
    tally_and_finish();
  end
endmodule
